// File: common/list_cmd_consts.vh
// Purpose: Offsets, field positions, reset values and timing counts for the list service
//          and command/status register block.
// Assumes: Core clock of 10 MHz (100 ns period).
// Notes: Notes on behaviour are listed below.
// Notes on behaviour
// RULE_01: The two-bit ratio field gives one to four control descriptors per bulk descriptor.
// RULE_02: Before each nonperiodic pick the ratio is compared with the served count.
// RULE_03: The served control count keeps its value across frame boundaries.
// RULE_04: After any reset the driver rewrites the ratio field with its intended value.
// RULE_05: A command/status write sets bits written as one and leaves the others alone.
// RULE_06: A read of the command/status register returns the current value of every bit.
// RULE_07: Bits 17 and 16 of the command/status register hold the overrun frame counter.
// RULE_08: An overrun is flagged when the periodic list is unfinished at the end of frame; the code flags none during soft reset.
// RULE_09: Each overrun bumps the counter and sets the overrun flag at interrupt status bit 0; the code does neither during soft reset.
// RULE_10: Software writes reserved command/status bits as zero.
// RULE_11: The overrun counter starts at zero, wraps from three and counts even if flagged.
// RULE_12: A pending ownership request sets the ownership-changed flag, cleared at changeover.
// RULE_13: Soft reset suspends, resets operational state but not the root hub, ends in 10 us.
// RULE_14: The driver sets the filled flags; a list start clears and a found transfer sets them.
// RULE_15: Hardware reset clears the served control count so scheduling starts with control.
`ifndef LIST_CMD_CONSTS_VH
`define LIST_CMD_CONSTS_VH

`define HOST_CONTROL_OFFSET 8'h04
`define COMMAND_STATUS_OFFSET 8'h08

`define CTRL_RATIO_LSB 0
`define CTRL_RATIO_MSB 1
`define CTRL_FSTATE_LSB 6
`define CTRL_FSTATE_MSB 7

`define CMD_SOFT_RESET_BIT 0
`define CMD_CTRL_FILLED_BIT 1
`define CMD_BULK_FILLED_BIT 2
`define CMD_OWN_REQ_BIT 3
`define CMD_OVERRUN_LSB 16
`define CMD_OVERRUN_MSB 17

`define HOST_CONTROL_RESET 32'h00000000
`define COMMAND_STATUS_RESET 32'h00000000

`define FSTATE_RESET 2'h0
`define FSTATE_SUSPEND 2'h3

`define SOFT_RESET_MAX_NS 10000
`define CLK_PERIOD_NS 100
`define SOFT_RESET_CYCLES (`SOFT_RESET_MAX_NS / `CLK_PERIOD_NS)

`endif

// File: rtl/list_ratio_select.v
// Purpose: Chooses control or bulk service from the ratio and the served count.
// Assumes: Count and ratio come from registers on the same clock.
// Notes: Purely combinational.
`timescale 1ns/10ps
`default_nettype none

module list_ratio_select
(
    // Inputs
    input wire [1:0] ratio_in,
    input wire [2:0] served_count_in,
    input wire ctrl_ready_in,
    input wire bulk_ready_in,
    // Outputs
    output reg pick_ctrl_out,
    output reg pick_bulk_out
);

    // A ratio code of n allows n+1 control descriptors before one bulk descriptor.
    always @*
    begin
        pick_ctrl_out = 1'b0;
        pick_bulk_out = 1'b0;
        if (ctrl_ready_in
            && (served_count_in <= {1'b0, ratio_in} || !bulk_ready_in)) // see RULE_01 RULE_02
        begin
            pick_ctrl_out = 1'b1;
        end
        else if (bulk_ready_in)
        begin
            pick_bulk_out = 1'b1;
        end
    end

endmodule
`default_nettype wire

// File: rtl/list_service_command_status.v
// Purpose: Control register ratio field and write-to-set command/status register of a
//          full-speed host controller core, with nonperiodic list arbitration.
// Assumes: Register port is a simple same-clock strobe interface at the documented offsets.
// Notes: Other control fields and the interrupt status register live elsewhere.
`timescale 1ns/10ps
`default_nettype none
`include "list_cmd_consts.vh"

module list_service_command_status
#(
    parameter SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
)
(
    // Clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // Register port
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    output reg [31:0] reg_rdata_out,
    // Scheduler events
    input wire eof_in,
    input wire periodic_done_in,
    input wire nonperiodic_req_in,
    input wire ctrl_td_found_in,
    input wire bulk_td_found_in,
    input wire changeover_done_in,
    // Scheduler decisions
    output reg serve_ctrl_out,
    output reg serve_bulk_out,
    // Interrupt status set pulses
    output reg overrun_flag_set_out,
    output reg ownership_changed_flag_set_out,
    // Soft reset controls
    output reg soft_reset_active_out,
    output reg suspended_state_out
);

    reg [1:0] control_bulk_ratio_reg;
    reg [2:0] served_count_reg;
    reg [1:0] overrun_count_reg;
    reg controller_soft_reset_reg;
    reg control_list_filled_reg;
    reg bulk_list_filled_reg;
    reg ownership_change_request_reg;
    reg own_flag_sent_reg;
    reg periodic_done_reg;
    reg [15:0] soft_reset_count_reg;

    wire wr_cmd;
    wire wr_ctrl;
    wire pick_ctrl;
    wire pick_bulk;
    wire [31:0] command_status_value;
    wire [31:0] host_control_value;
    wire overrun_event;
    wire count_below_limit;

    assign wr_cmd = reg_wr_in && (reg_addr_in == `COMMAND_STATUS_OFFSET);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `HOST_CONTROL_OFFSET);
    assign overrun_event = eof_in && !periodic_done_reg; // see RULE_08
    assign count_below_limit = served_count_reg <= {1'b0, control_bulk_ratio_reg};

    // =====================================================================
    // Read values
    // =====================================================================
    assign command_status_value = {14'h0000, overrun_count_reg, 12'h000, // see RULE_07
        ownership_change_request_reg, bulk_list_filled_reg,
        control_list_filled_reg, controller_soft_reset_reg};
    assign host_control_value = {24'h000000,
        (suspended_state_out ? `FSTATE_SUSPEND : `FSTATE_RESET), 4'h0,
        control_bulk_ratio_reg};

    list_ratio_select list_ratio_select_inst
    (
        .ratio_in(control_bulk_ratio_reg),
        .served_count_in(served_count_reg),
        .ctrl_ready_in(control_list_filled_reg),
        .bulk_ready_in(bulk_list_filled_reg),
        .pick_ctrl_out(pick_ctrl),
        .pick_bulk_out(pick_bulk)
    );

    // =====================================================================
    // Register port
    // =====================================================================
    always @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            reg_rdata_out <= `COMMAND_STATUS_RESET;
        end
        else if (reg_rd_in && reg_addr_in == `COMMAND_STATUS_OFFSET)
        begin
            reg_rdata_out <= command_status_value; // see RULE_06
        end
        else if (reg_rd_in && reg_addr_in == `HOST_CONTROL_OFFSET)
        begin
            reg_rdata_out <= host_control_value;
        end
        else
        begin
            reg_rdata_out <= 32'h00000000;
        end
    end

    // =====================================================================
    // Ratio field, served count and list arbitration
    // =====================================================================
    always @(posedge core_clk_in)
    begin
        if (sys_rst_in || soft_reset_active_out)
        begin
            control_bulk_ratio_reg <= 2'h0;
            served_count_reg <= 3'h0; // see RULE_15
            serve_ctrl_out <= 1'b0;
            serve_bulk_out <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                control_bulk_ratio_reg <= reg_wdata_in[`CTRL_RATIO_MSB:`CTRL_RATIO_LSB];
            end
            serve_ctrl_out <= nonperiodic_req_in && pick_ctrl; // see RULE_02
            serve_bulk_out <= nonperiodic_req_in && pick_bulk;
            // The count is not touched by eof_in so it survives frame boundaries.
            // The count stops one past the ratio so control-only service cannot wrap it.
            if (nonperiodic_req_in && pick_ctrl && count_below_limit) // see RULE_03
            begin
                served_count_reg <= served_count_reg + 3'h1;
            end
            else if (nonperiodic_req_in && pick_bulk)
            begin
                served_count_reg <= 3'h0;
            end
        end
    end

    // =====================================================================
    // Command/status bits
    // =====================================================================
    always @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            controller_soft_reset_reg <= 1'b0;
            control_list_filled_reg <= 1'b0;
            bulk_list_filled_reg <= 1'b0;
            ownership_change_request_reg <= 1'b0;
            own_flag_sent_reg <= 1'b0;
            overrun_count_reg <= 2'h0; // see RULE_11
            periodic_done_reg <= 1'b0;
            overrun_flag_set_out <= 1'b0;
            ownership_changed_flag_set_out <= 1'b0;
            soft_reset_count_reg <= 16'h0000;
            soft_reset_active_out <= 1'b0;
            suspended_state_out <= 1'b0;
        end
        else
        begin
            // Periodic completion is tracked per frame and rearmed at each end of frame.
            if (eof_in)
            begin
                periodic_done_reg <= 1'b0;
            end
            else if (periodic_done_in)
            begin
                periodic_done_reg <= 1'b1;
            end
            overrun_flag_set_out <= overrun_event && !soft_reset_active_out; // see RULE_09
            if (overrun_event && !soft_reset_active_out)
            begin
                overrun_count_reg <= overrun_count_reg + 2'h1; // see RULE_11
            end
            // Filled flags are cleared when a list is taken and set by a write or a found TD.
            if ((wr_cmd && reg_wdata_in[`CMD_CTRL_FILLED_BIT]) || ctrl_td_found_in) // see RULE_14
            begin
                control_list_filled_reg <= 1'b1;
            end
            else if (serve_ctrl_out || soft_reset_active_out)
            begin
                control_list_filled_reg <= 1'b0;
            end
            if ((wr_cmd && reg_wdata_in[`CMD_BULK_FILLED_BIT]) || bulk_td_found_in) // see RULE_14
            begin
                bulk_list_filled_reg <= 1'b1;
            end
            else if (serve_bulk_out || soft_reset_active_out)
            begin
                bulk_list_filled_reg <= 1'b0;
            end
            // Ownership request: flag once per request, cleared at changeover unless rewritten.
            ownership_changed_flag_set_out <= ownership_change_request_reg
                && !own_flag_sent_reg; // see RULE_12
            if (wr_cmd && reg_wdata_in[`CMD_OWN_REQ_BIT]) // see RULE_05
            begin
                ownership_change_request_reg <= 1'b1;
            end
            else if (changeover_done_in)
            begin
                ownership_change_request_reg <= 1'b0;
            end
            // Rearming at changeover lets a request rewritten in that cycle flag again.
            if (!ownership_change_request_reg || changeover_done_in)
            begin
                own_flag_sent_reg <= 1'b0;
            end
            else
            begin
                own_flag_sent_reg <= 1'b1;
            end
            // Soft reset: held for a fixed time, then the bit self-clears.
            if (wr_cmd && reg_wdata_in[`CMD_SOFT_RESET_BIT]) // see RULE_05
            begin
                controller_soft_reset_reg <= 1'b1;
            end
            else if (soft_reset_active_out && soft_reset_count_reg == 16'h0001) // see RULE_13
            begin
                controller_soft_reset_reg <= 1'b0;
            end
            if (controller_soft_reset_reg && !soft_reset_active_out)
            begin
                soft_reset_active_out <= 1'b1;
                suspended_state_out <= 1'b1; // see RULE_13
                soft_reset_count_reg <= SOFT_RESET_CYCLES[15:0] - 16'h0001;
            end
            else if (soft_reset_active_out)
            begin
                if (soft_reset_count_reg == 16'h0001)
                begin
                    soft_reset_active_out <= 1'b0;
                end
                soft_reset_count_reg <= soft_reset_count_reg - 16'h0001;
            end
        end
    end

endmodule
`default_nettype wire

// File: test/list_cmd_properties.sv
// Purpose: Port-level assertions for the list service and command/status block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module list_cmd_properties
#(
    parameter SOFT_RESET_CYCLES = 100
)
(
    // Clock, reset and stimulus
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic eof_in,
    input wire logic periodic_done_in,
    input wire logic nonperiodic_req_in,
    // Block outputs
    input wire logic [31:0] reg_rdata_out,
    input wire logic serve_ctrl_out,
    input wire logic serve_bulk_out,
    input wire logic overrun_flag_set_out,
    input wire logic ownership_changed_flag_set_out,
    input wire logic soft_reset_active_out,
    input wire logic suspended_state_out
);
    logic done_seen_reg;
    logic [7:0] active_cnt_reg;
    wire cmd_wr = reg_wr_in && reg_addr_in == 8'h08;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ==========================================================
    // Helper logic
    always @(posedge core_clk_in)
    begin
        if (sys_rst_in || eof_in)
            done_seen_reg <= 1'b0;
        else if (periodic_done_in)
            done_seen_reg <= 1'b1;
        active_cnt_reg <= (sys_rst_in || !soft_reset_active_out) ? 8'h00 : active_cnt_reg + 8'h01;
    end
    // ==========================================================
    // Assertions
    chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    chk_serve_exclusive: assert property (!(serve_ctrl_out && serve_bulk_out))
        else $error("control and bulk served together");
    chk_serve_cause: assert property ((serve_ctrl_out || serve_bulk_out)
        |-> $past(nonperiodic_req_in))
        else $error("service decision without request");
    chk_overrun_detect: assert property (eof_in && !done_seen_reg && !periodic_done_in
        |=> overrun_flag_set_out)
        else $error("missed overrun at end of frame");
    chk_overrun_cause: assert property (overrun_flag_set_out |-> $past(eof_in))
        else $error("overrun flag pulse without end of frame");
    chk_owner_flag: assert property (cmd_wr && reg_wdata_in[3]
        |-> ##2 ownership_changed_flag_set_out)
        else $error("ownership changed flag not raised");
    chk_soft_enter: assert property (cmd_wr && reg_wdata_in[0] && !soft_reset_active_out
        |-> ##2 soft_reset_active_out && suspended_state_out)
        else $error("soft reset did not start");
    chk_soft_bound: assert property (active_cnt_reg <= SOFT_RESET_CYCLES)
        else $error("soft reset lasted too long");
    chk_suspend_sticky: assert property (suspended_state_out |=> suspended_state_out)
        else $error("suspend left without hardware reset");
    cover property (serve_bulk_out);
    cover property (overrun_flag_set_out);
    cover property (soft_reset_active_out);
    cover property (ownership_changed_flag_set_out);
endmodule
bind list_service_command_status list_cmd_properties #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES))
    list_cmd_properties_inst (.core_clk_in, .sys_rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .eof_in, .periodic_done_in, .nonperiodic_req_in, .reg_rdata_out,
    .serve_ctrl_out, .serve_bulk_out, .overrun_flag_set_out, .ownership_changed_flag_set_out,
    .soft_reset_active_out, .suspended_state_out);
`default_nettype wire

// File: test/tb_top.sv
// Purpose: Self-checking bench for the list service and command/status block.
// Assumes: Soft reset shortened to four cycles.
// Notes: Inputs change 10 ns after each rising edge.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic eof_in = 1'b0;
    logic periodic_done_in = 1'b0;
    logic nonperiodic_req_in = 1'b0;
    logic changeover_done_in = 1'b0;
    logic ctrl_td_found_in = 1'b0;
    logic bulk_td_found_in = 1'b0;
    wire [31:0] reg_rdata_out;
    wire serve_ctrl_out, serve_bulk_out, overrun_flag_set_out;
    wire ownership_changed_flag_set_out, soft_reset_active_out, suspended_state_out;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] rdata;
    logic [31:0] cmd = 32'h0;
    logic [31:0] d;
    logic [1:0] soc = 2'h0;
    always #50 core_clk_in = ~core_clk_in;
    list_service_command_status #(.SOFT_RESET_CYCLES(4)) list_service_command_status_inst (
        .core_clk_in, .sys_rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
        .reg_rdata_out, .eof_in, .periodic_done_in, .nonperiodic_req_in,
        .ctrl_td_found_in, .bulk_td_found_in, .changeover_done_in,
        .serve_ctrl_out, .serve_bulk_out, .overrun_flag_set_out,
        .ownership_changed_flag_set_out, .soft_reset_active_out, .suspended_state_out);
    // ==========================================================
    // Bench tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic step;
        @(posedge core_clk_in);
        #10;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        step;
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = v;
        step;
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        step;
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        step;
        reg_rd_in = 1'b0;
        rdata = reg_rdata_out;
    endtask
    task automatic pulse(ref logic s);
        step;
        s = 1'b1;
        step;
        s = 1'b0;
    endtask
    function automatic logic expect_ctrl(input int r, input int k);
        return (k % (r + 2)) < (r + 1);
    endfunction
    task automatic end_of_test;
        $display("Checks: %0d, errors: %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #500000;
        num_errors++;
        end_of_test;
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'hd030));
        repeat (6) @(posedge core_clk_in);
        #10;
        sys_rst_in = 1'b0;
        rd(8'h04);
        check(rdata, 32'h0);
        rd(8'h08);
        check(rdata, 32'h0);
        rd(8'h0c);
        check(rdata, 32'h0);
        repeat (8)
        begin
            d = $urandom & 32'h6;
            wr(8'h08, d);
            cmd = cmd | d;
            rd(8'h08);
            check(rdata, cmd);
        end
        for (int r = 0; r < 4; r++)
        begin
            wr(8'h04, 32'(r));
            rd(8'h04);
            check(rdata & 32'h3, 32'(r));
            for (int k = 0; k < 2 * (r + 2); k++)
            begin
                if (k == 1)
                begin
                    pulse(eof_in);
                    check(overrun_flag_set_out, 1'b1);
                    soc = soc + 2'h1;
                end
                wr(8'h08, 32'h6);
                pulse(nonperiodic_req_in);
                check(serve_ctrl_out, expect_ctrl(r, k));
                check(serve_bulk_out, !expect_ctrl(r, k));
            end
        end
        // A served list clears its flag and a found transfer sets it again.
        pulse(nonperiodic_req_in);
        check(serve_ctrl_out, 1'b1);
        rd(8'h08);
        check(rdata & 32'h6, 32'h0);
        pulse(bulk_td_found_in);
        pulse(nonperiodic_req_in);
        check({serve_ctrl_out, serve_bulk_out}, 2'b01);
        pulse(nonperiodic_req_in);
        check({serve_ctrl_out, serve_bulk_out}, 2'b00);
        pulse(ctrl_td_found_in);
        pulse(nonperiodic_req_in);
        check({serve_ctrl_out, serve_bulk_out}, 2'b10);
        pulse(periodic_done_in);
        pulse(eof_in);
        check(overrun_flag_set_out, 1'b0);
        pulse(eof_in);
        soc = soc + 2'h1;
        rd(8'h08);
        check(rdata & 32'h30000, {14'h0, soc, 16'h0});
        wr(8'h08, 32'h8);
        step;
        check(ownership_changed_flag_set_out, 1'b1);
        rd(8'h08);
        check(rdata & 32'h8, 32'h8);
        pulse(changeover_done_in);
        rd(8'h08);
        check(rdata & 32'h8, 32'h0);
        wr(8'h08, 32'h1);
        step;
        check({soft_reset_active_out, suspended_state_out}, 2'b11);
        repeat (8) step;
        rd(8'h08);
        check(rdata, {14'h0, soc, 16'h0});
        rd(8'h04);
        check(rdata, 32'h000000c0);
        check({soft_reset_active_out, suspended_state_out}, 2'b01);
        end_of_test;
    end
endmodule
`default_nettype wire
